// File: verilog/prd_pkg.sv
package prd_pkg;

    // ****************************************************************
    // Field widths and multiplier encoding
    // ****************************************************************
    // Multiplier is held in half steps: value = 2 * ratio
    localparam int CFG_W = 6;
    localparam int MULT_W = 7;

    localparam logic [5:0] CFG_11X = 6'h26;
    localparam logic [5:0] CFG_11_5X = 6'h00;
    localparam logic [5:0] CFG_12X = 6'h2E;
    localparam logic [5:0] CFG_12_5X = 6'h3E;
    localparam logic [5:0] CFG_13X = 6'h16;
    localparam logic [5:0] CFG_13_5X = 6'h38;
    localparam logic [5:0] CFG_14X = 6'h32;
    localparam logic [5:0] CFG_15X = 6'h06;
    localparam logic [5:0] CFG_16X = 6'h36;
    localparam logic [5:0] CFG_17X = 6'h02;
    localparam logic [5:0] CFG_18X = 6'h0A;
    localparam logic [5:0] CFG_20X = 6'h0E;
    localparam logic [5:0] CFG_21X = 6'h12;
    localparam logic [5:0] CFG_24X = 6'h1A;
    localparam logic [5:0] CFG_28X = 6'h3A;
    localparam logic [5:0] CFG_BYPASS = 6'h0C;
    localparam logic [5:0] CFG_OFF = 6'h3C;

    // Low-multiplier threshold for delayed address acknowledge, 5x
    localparam logic [6:0] ACK_DELAY_LIMIT = 7'h0A;
    localparam logic [6:0] CORE_VCO_MULT = 7'h02;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        PRD_MODE_PLL,
        PRD_MODE_BYPASS,
        PRD_MODE_OFF,
        PRD_MODE_RESERVED
    } prd_mode_t;

    typedef struct packed {
        prd_mode_t mode;
        logic [6:0] bus_mult;
        logic [6:0] vco_mult;
    } prd_cfg_t;

    typedef struct packed {
        logic core_clk_en;
        logic bus_clk_en;
        logic ack_delay_req;
        logic [6:0] eff_mult;
    } prd_status_t;

endpackage : prd_pkg

// File: verilog/prd_ratio_table.sv
`timescale 1ns/1ps
module prd_ratio_table (
    input wire logic [5:0] cfg_code,
    output prd_pkg::prd_cfg_t cfg
);

    // ****************************************************************
    // Code to multiplier lookup
    // ****************************************************************
    always_comb begin
        cfg.mode = prd_pkg::PRD_MODE_PLL;
        cfg.vco_mult = prd_pkg::CORE_VCO_MULT;
        case (cfg_code)
            prd_pkg::CFG_11X: cfg.bus_mult = 7'h16;
            prd_pkg::CFG_11_5X: cfg.bus_mult = 7'h17;
            prd_pkg::CFG_12X: cfg.bus_mult = 7'h18;
            prd_pkg::CFG_12_5X: cfg.bus_mult = 7'h19;
            prd_pkg::CFG_13X: cfg.bus_mult = 7'h1A;
            prd_pkg::CFG_13_5X: cfg.bus_mult = 7'h1B;
            prd_pkg::CFG_14X: cfg.bus_mult = 7'h1C;
            prd_pkg::CFG_15X: cfg.bus_mult = 7'h1E;
            prd_pkg::CFG_16X: cfg.bus_mult = 7'h20;
            prd_pkg::CFG_17X: cfg.bus_mult = 7'h22;
            prd_pkg::CFG_18X: cfg.bus_mult = 7'h24;
            prd_pkg::CFG_20X: cfg.bus_mult = 7'h28;
            prd_pkg::CFG_21X: cfg.bus_mult = 7'h2A;
            prd_pkg::CFG_24X: cfg.bus_mult = 7'h30;
            prd_pkg::CFG_28X: cfg.bus_mult = 7'h38;
            prd_pkg::CFG_BYPASS: begin
                cfg.mode = prd_pkg::PRD_MODE_BYPASS;
                cfg.bus_mult = 7'h02;
                cfg.vco_mult = 7'h00;
            end
            prd_pkg::CFG_OFF: begin
                cfg.mode = prd_pkg::PRD_MODE_OFF;
                cfg.bus_mult = 7'h00;
                cfg.vco_mult = 7'h00;
            end
            default: begin
                cfg.mode = prd_pkg::PRD_MODE_RESERVED;
                cfg.bus_mult = 7'h00;
                cfg.vco_mult = 7'h00;
            end
        endcase
    end

endmodule : prd_ratio_table

// File: verilog/prd_pll_ratio_decode.sv
// Summary of operation
// - Six-bit strap decodes to bus-to-core multiplier, core-to-VCO 1x.
// - Code 001100 bypasses the PLL; bus clock drives core directly.
// - In bypass the bus interface runs at half the input clock.
// - Code 111100 turns PLL off; no core clocking at all.
// - Decoded multipliers hold until reset; frequency switching only alters eff_mult and ack_delay_req.
// - In PLL mode, frequency switching divides ratio by two or four in one cycle; both requests together leave it undivided.
`timescale 1ns/1ps
module prd_pll_ratio_decode (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] ratio_select,
    input wire logic bypass_clock_qualifier,
    input wire logic dfs_div2_req,
    input wire logic dfs_div4_req,
    output prd_pkg::prd_mode_t clock_mode,
    output logic [6:0] bus_mult,
    output logic [6:0] vco_mult,
    output prd_pkg::prd_status_t status,
    output logic cfg_reserved
);

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    logic [5:0] strap_q;
    logic [5:0] strap_d;
    logic armed_q;
    logic armed_d;
    prd_pkg::prd_cfg_t cfg;

    always_comb begin
        strap_d = strap_q;
        armed_d = 1'b1;
        if (!armed_q) begin
            strap_d = ratio_select;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_q <= prd_pkg::CFG_OFF;
            armed_q <= 1'b0;
        end else begin
            strap_q <= strap_d;
            armed_q <= armed_d;
        end
    end

    prd_ratio_table u_table (
        .cfg_code(strap_q),
        .cfg(cfg)
    );

    // ****************************************************************
    // Clock enables and frequency switching
    // ****************************************************************
    function automatic logic [6:0] prd_div(input logic [6:0] m,
                                           input logic d2,
                                           input logic d4);
        logic [6:0] r;
        r = m;
        if (d2 && d4) begin
            r = m;
        end else if (d4) begin
            r = m >> 2;
        end else if (d2) begin
            r = m >> 1;
        end
        return r;
    endfunction : prd_div

    prd_pkg::prd_status_t status_d;
    prd_pkg::prd_status_t status_q;
    prd_pkg::prd_mode_t mode_q;
    logic [6:0] bus_mult_q;
    logic [6:0] vco_mult_q;
    logic qual_q;

    always_comb begin
        status_d.core_clk_en = 1'b0;
        status_d.bus_clk_en = 1'b0;
        status_d.eff_mult = 7'h00;
        case (cfg.mode)
            prd_pkg::PRD_MODE_PLL: begin
                status_d.core_clk_en = 1'b1;
                status_d.bus_clk_en = 1'b1;
                status_d.eff_mult = prd_div(cfg.bus_mult, dfs_div2_req,
                                            dfs_div4_req);
            end
            prd_pkg::PRD_MODE_BYPASS: begin
                status_d.core_clk_en = 1'b1;
                status_d.bus_clk_en = bypass_clock_qualifier & ~qual_q;
                status_d.eff_mult = cfg.bus_mult;
            end
            prd_pkg::PRD_MODE_OFF: begin
                status_d.core_clk_en = 1'b0;
                status_d.bus_clk_en = 1'b0;
            end
            default: begin
                status_d.core_clk_en = 1'b0;
                status_d.bus_clk_en = 1'b0;
            end
        endcase
        status_d.ack_delay_req = (status_d.eff_mult != 7'h00) &&
            (status_d.eff_mult < prd_pkg::ACK_DELAY_LIMIT);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_q <= '0;
            mode_q <= prd_pkg::PRD_MODE_OFF;
            bus_mult_q <= 7'h00;
            vco_mult_q <= 7'h00;
            qual_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mode_q <= cfg.mode;
            bus_mult_q <= cfg.bus_mult;
            vco_mult_q <= cfg.vco_mult;
            qual_q <= bypass_clock_qualifier;
        end
    end

    assign clock_mode = mode_q;
    assign bus_mult = bus_mult_q;
    assign vco_mult = vco_mult_q;
    assign status = status_q;
    assign cfg_reserved = (mode_q == prd_pkg::PRD_MODE_RESERVED);

endmodule : prd_pll_ratio_decode

// File: testbench/prd_board_model.sv
`timescale 1ns/1ps
module prd_board_model (
    input wire logic ref_clk,
    input wire logic qual_en,
    output logic bypass_clock_qualifier
);
    initial bypass_clock_qualifier = 1'b0;
    // Half-rate qualifier, offset 1 ns from the bus clock edge
    always @(posedge ref_clk) begin
        bypass_clock_qualifier <= #1 qual_en & ~bypass_clock_qualifier;
    end
endmodule : prd_board_model

// File: testbench/prd_pll_ratio_decode_monitor.sv
`timescale 1ns/1ps
module prd_pll_ratio_decode_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] ratio_select,
    input wire logic bypass_clock_qualifier,
    input wire logic dfs_div2_req,
    input wire logic dfs_div4_req,
    input prd_pkg::prd_mode_t clock_mode,
    input logic [6:0] bus_mult,
    input logic [6:0] vco_mult,
    input prd_pkg::prd_status_t status,
    input logic cfg_reserved
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_pll_vco_ratio: assert property (
        clock_mode == prd_pkg::PRD_MODE_PLL |->
        vco_mult == prd_pkg::CORE_VCO_MULT) else $error("vco ratio");
    a_bypass_core_clk: assert property (
        clock_mode == prd_pkg::PRD_MODE_BYPASS |-> status.core_clk_en)
        else $error("bypass core clock");
    a_bypass_bus_half: assert property (
        clock_mode == prd_pkg::PRD_MODE_BYPASS &&
        $rose(bypass_clock_qualifier) |=>
        status.bus_clk_en ##1 !status.bus_clk_en) else $error("bus rate");
    a_off_no_clock: assert property (
        clock_mode == prd_pkg::PRD_MODE_OFF && $past(clock_mode) ==
        prd_pkg::PRD_MODE_OFF |-> !status.core_clk_en && !status.bus_clk_en)
        else $error("clock while off");
    a_nodfs_mult: assert property (
        clock_mode == prd_pkg::PRD_MODE_PLL && $past(clock_mode) ==
        prd_pkg::PRD_MODE_PLL && $past(dfs_div2_req) == $past(dfs_div4_req)
        |-> status.eff_mult == bus_mult) else $error("undivided mult");
    a_dfs_divide: assert property (
        clock_mode == prd_pkg::PRD_MODE_PLL && $past(clock_mode) ==
        prd_pkg::PRD_MODE_PLL && bus_mult[1:0] == 2'h0 &&
        $past(dfs_div2_req) != $past(dfs_div4_req) |-> status.eff_mult ==
        ($past(dfs_div4_req) ? bus_mult >> 2 : bus_mult >> 1))
        else $error("divided mult");
    a_mode_held: assert property (
        $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
        $stable(clock_mode) && $stable(bus_mult)) else $error("mode moved");
endmodule : prd_pll_ratio_decode_monitor
bind prd_pll_ratio_decode prd_pll_ratio_decode_monitor i_mon (.ref_clk,
    .rst_n, .ratio_select, .bypass_clock_qualifier, .dfs_div2_req,
    .dfs_div4_req, .clock_mode, .bus_mult, .vco_mult, .status, .cfg_reserved);

// File: testbench/prd_pll_ratio_decode_bench.sv
`timescale 1ns/1ps
module prd_pll_ratio_decode_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] ratio_select = 6'h3C;
    logic qual_en = 1'b0;
    logic bypass_clock_qualifier;
    logic dfs_div2_req = 1'b0;
    logic dfs_div4_req = 1'b0;
    prd_pkg::prd_mode_t clock_mode;
    logic [6:0] bus_mult;
    logic [6:0] vco_mult;
    prd_pkg::prd_status_t status;
    logic cfg_reserved;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic [5:0] codes [5] = '{6'h26, 6'h00, 6'h06, 6'h3A, 6'h1A};
    logic [6:0] mults [5] = '{7'h16, 7'h17, 7'h1E, 7'h38, 7'h30};
    logic [7:0] n;
    always #2 ref_clk = ~ref_clk;
    prd_board_model i_board (.ref_clk, .qual_en, .bypass_clock_qualifier);
    prd_pll_ratio_decode i_dut (.ref_clk, .rst_n, .ratio_select,
        .bypass_clock_qualifier, .dfs_div2_req, .dfs_div4_req, .clock_mode,
        .bus_mult, .vco_mult, .status, .cfg_reserved);
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task boot(input logic [5:0] c);
        @(posedge ref_clk);
        #1 rst_n = 1'b0;
        ratio_select = c;
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : boot
    task dfs_step(input logic d2, input logic d4, input logic [6:0] exp);
        @(posedge ref_clk);
        #1 dfs_div2_req = d2;
        dfs_div4_req = d4;
        @(posedge ref_clk);
        #1 check(status.eff_mult, exp);
    endtask : dfs_step
    task t_ratios;
        for (int i = 0; i < 5; i++) begin
            boot(codes[i]);
            check(clock_mode, prd_pkg::PRD_MODE_PLL);
            check(bus_mult, mults[i]);
            check(vco_mult, prd_pkg::CORE_VCO_MULT);
            ratio_select = prd_pkg::CFG_OFF;
            repeat (3) @(posedge ref_clk);
            #1 check(bus_mult, mults[i]);
        end
    endtask : t_ratios
    task t_bypass;
        qual_en = 1'b1;
        boot(prd_pkg::CFG_BYPASS);
        n = 8'h00;
        repeat (8) begin
            @(posedge ref_clk);
            #1 n = n + 8'(status.bus_clk_en);
        end
        check(clock_mode, prd_pkg::PRD_MODE_BYPASS);
        check(status.core_clk_en, 1'b1);
        check(n, 8'h04);
        check(status.ack_delay_req, 1'b1);
    endtask : t_bypass
    task t_off;
        boot(prd_pkg::CFG_OFF);
        check(clock_mode, prd_pkg::PRD_MODE_OFF);
        check({status.core_clk_en, status.bus_clk_en}, 8'h00);
        qual_en = 1'b0;
    endtask : t_off
    task t_dfs;
        boot(prd_pkg::CFG_24X);
        dfs_step(1'b1, 1'b0, 7'h18);
        dfs_step(1'b0, 1'b1, 7'h0C);
        dfs_step(1'b1, 1'b1, 7'h30);
        dfs_step(1'b0, 1'b0, 7'h30);
    endtask : t_dfs
    task t_ack;
        boot(prd_pkg::CFG_11X);
        check(status.ack_delay_req, 1'b0);
        dfs_step(1'b0, 1'b1, 7'h05);
        check(status.ack_delay_req, 1'b1);
        dfs_step(1'b0, 1'b0, 7'h16);
        check(status.ack_delay_req, 1'b0);
    endtask : t_ack
    task t_reserved;
        boot(6'h01);
        check(cfg_reserved, 1'b1);
        check(clock_mode, prd_pkg::PRD_MODE_RESERVED);
    endtask : t_reserved
    task test_done;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        t_ratios();
        t_bypass();
        t_off();
        t_dfs();
        t_ack();
        t_reserved();
        test_done();
    end
endmodule : prd_pll_ratio_decode_bench
